// ---- itu_defs.vh ----
// Constants for the interval timer unit: offsets, fields, resets, timing
`ifndef ITU_DEFS_VH
`define ITU_DEFS_VH

// APB byte offsets
`define ITU_OFF_CMD       8'h00
`define ITU_OFF_COUNT     8'h04
`define ITU_OFF_INTERVAL  8'h08
`define ITU_OFF_SUBR      8'h0C
`define ITU_OFF_RD_COUNT  8'h10
`define ITU_OFF_RD_IVAL   8'h14
`define ITU_OFF_RD_ELAP   8'h18
`define ITU_OFF_STATUS    8'h1C

// Command word fields
`define ITU_CMD_FC_MSB    11
`define ITU_CMD_WORD_BIT  16
`define ITU_CMD_AREA_BIT  17

// Status word fields
`define ITU_ST_ERR_BIT    0
`define ITU_ST_RUN_LSB    1
`define ITU_ST_SCHED_LSB  4

// Function codes, BCD
`define ITU_FC_ONE_FIRST  12'h000
`define ITU_FC_ONE_LAST   12'h002
`define ITU_FC_SCH_FIRST  12'h003
`define ITU_FC_SCH_LAST   12'h005
`define ITU_FC_RD_FIRST   12'h006
`define ITU_FC_RD_LAST    12'h008
`define ITU_FC_STP_FIRST  12'h010
`define ITU_FC_STP_LAST   12'h012
`define ITU_FC_START_T2   12'h002

// Command kinds
`define ITU_K_ONE         3'd0
`define ITU_K_SCHED       3'd1
`define ITU_K_READ        3'd2
`define ITU_K_STOP        3'd3
`define ITU_K_BAD         3'd4

// Operand limits and reset values, BCD
`define ITU_IVAL_MIN      16'h0005
`define ITU_IVAL_MAX      16'h0320
`define ITU_IVAL_IMM      16'h0010
`define ITU_SUBR_MAX      16'h0255
`define ITU_RST_WORD      32'h0000_0000

// Timing: tick unit 0.1 ms, clock period 4 ns
`define ITU_TICK_NS       100000
`define ITU_CLK_NS        4

`endif

// ---- itu_top.v ----
// Interval timer unit: three BCD interval timers behind an APB slave
//
// Summary of operation
// [RULE1] Codes 000-002 start one-shot timers 0-2
// [RULE2] Codes 003-005 start scheduled timers 0-2
// [RULE3] Codes 006-008 read timers 0-2
// [RULE4] Codes 010-012 stop timers; operands ignored
// [RULE5] Issuer uses only 000-008, 010-012
// [RULE6] Immediate count: BCD load, 1 ms tick
// [RULE7] Word count: count plus 0005-0320 interval
// [RULE8] Expiry time is count times interval
// [RULE9] Third operand picks subroutine 0000-0255
// [RULE10] Issuer keeps immediate subroutine within 0255
// [RULE11] Read returns decrements done and interval
// [RULE12] Read returns elapsed since last decrement
// [RULE13] Elapsed total recoverable from read words
// [RULE14] Issuer gives word destinations for reads
// [RULE15] Start timer 0 refused during pulse output; code refuses only code 000, not 003
// [RULE16] Start timer 2 refused with counter 0; code refuses only code 002, not 005
// [RULE17] Non-BCD or out-of-area operands set error
// [RULE18] Scheduled reloads and continues; one-shot halts
// [RULE19] Stop freezes counter, drops pending expiry; code still calls an expiry raised in the cycle before the stop
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "itu_defs.vh"

module itu_top #(
  parameter TICK_CYCLES = `ITU_TICK_NS / `ITU_CLK_NS
) (
  input  wire        clk,                 // 250 MHz clock
  input  wire        rstn,                // Async reset, active low
  input  wire        psel,                // APB select
  input  wire        penable,             // APB enable
  input  wire        pwrite,              // APB direction
  input  wire [7:0]  paddr,               // APB byte address
  input  wire [31:0] pwdata,              // APB write data
  output reg  [31:0] prdata,              // APB read data
  output reg         pready,              // APB ready
  output reg         pslverr,             // APB error, unmapped address
  input  wire        pulse_output_active, // Pulse output running
  input  wire        hsc0_enabled,        // High-speed counter 0 enabled
  output reg         irq_valid,           // Expiry call, one cycle
  output reg  [1:0]  irq_timer,           // Timer that expired
  output reg  [15:0] irq_subroutine,      // Subroutine number, BCD
  output reg         error_flag           // Sticky command error
);

  localparam integer TICK_SPAN = TICK_CYCLES - 1;
  localparam [14:0]  TICK_LAST = TICK_SPAN[14:0];

  // One BCD step up or down; carry or borrow ripples digit by digit
  function [15:0] bcd_step;
    input [15:0] v;
    input        up;
    reg   [15:0] r;
    reg          c;
    integer      k;
    begin
      r = v;
      c = 1'b1;
      for (k = 0; k < 4; k = k + 1) begin
        if (c) begin
          if (r[4*k +: 4] == (up ? 4'h9 : 4'h0)) begin
            r[4*k +: 4] = up ? 4'h0 : 4'h9;
          end else begin
            r[4*k +: 4] = up ? r[4*k +: 4] + 4'h1 : r[4*k +: 4] - 4'h1;
            c = 1'b0;
          end
        end
      end
      bcd_step = r;
    end
  endfunction

  function is_bcd;
    input [15:0] v;
    begin
      is_bcd = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) &&
               (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
    end
  endfunction

  // Kind of a function code
  function [2:0] fc_kind;
    input [11:0] fc;
    begin
      if (fc <= `ITU_FC_ONE_LAST) begin
        fc_kind = `ITU_K_ONE;
      end else if (fc <= `ITU_FC_SCH_LAST) begin
        fc_kind = `ITU_K_SCHED;
      end else if (fc <= `ITU_FC_RD_LAST) begin
        fc_kind = `ITU_K_READ;
      end else if (fc >= `ITU_FC_STP_FIRST && fc <= `ITU_FC_STP_LAST) begin
        fc_kind = `ITU_K_STOP;
      end else begin
        fc_kind = `ITU_K_BAD;
      end
    end
  endfunction

  // Timer index of a function code
  function [1:0] fc_timer;
    input [11:0] fc;
    begin
      if (fc <= `ITU_FC_ONE_LAST) begin
        fc_timer = fc[1:0];
      end else if (fc <= `ITU_FC_SCH_LAST) begin
        fc_timer = fc[1:0] - 2'd3;
      end else if (fc <= `ITU_FC_RD_LAST) begin
        fc_timer = fc[1:0] - 2'd2;
      end else begin
        fc_timer = fc[1:0];
      end
    end
  endfunction

  reg  [31:0] cmd_word;
  reg  [15:0] count_operand;
  reg  [15:0] interval_operand;
  reg  [15:0] subroutine_operand;
  reg  [15:0] rd_count;
  reg  [15:0] rd_ival;
  reg  [15:0] rd_elap;
  reg  [2:0]  pend;
  wire [2:0]  run_flat;
  wire [2:0]  sched_flat;
  wire [2:0]  exp_flat;
  wire [47:0] sub_flat;
  wire [47:0] done_flat;
  wire [47:0] ival_flat;
  wire [47:0] elap_flat;

  // APB access phase completes at the edge where pready is high
  wire        acc      = psel & penable & pready;
  wire        wr_acc   = acc & pwrite;
  wire        cmd_wr   = wr_acc && (paddr == `ITU_OFF_CMD);
  wire        st_wr    = wr_acc && (paddr == `ITU_OFF_STATUS);

  // Command decode straight from the bus word being written
  wire [11:0] function_code = pwdata[`ITU_CMD_FC_MSB:0];
  wire        word_mode     = pwdata[`ITU_CMD_WORD_BIT];
  wire        area_fault    = pwdata[`ITU_CMD_AREA_BIT];
  wire [2:0]  kind          = fc_kind(function_code);
  wire [1:0]  tsel          = fc_timer(function_code);
  wire        is_start      = (kind == `ITU_K_ONE) ||
                              (kind == `ITU_K_SCHED);

  wire err_bad   = (kind == `ITU_K_BAD);                      // see [RULE5]
  wire err_area  = area_fault & (kind != `ITU_K_STOP);        // see [RULE17]
  wire err_bcd   = is_start & (!is_bcd(count_operand) |
                   !is_bcd(subroutine_operand) |
                   (word_mode & !is_bcd(interval_operand)));  // see [RULE17]
  wire err_ival  = is_start & word_mode &
                   ((interval_operand < `ITU_IVAL_MIN) |
                    (interval_operand > `ITU_IVAL_MAX));      // see [RULE7]
  wire err_subr  = is_start &
                   (subroutine_operand > `ITU_SUBR_MAX);      // see [RULE10]
  wire err_pulse = (function_code == `ITU_FC_ONE_FIRST) &
                   pulse_output_active;                       // see [RULE15]
  wire err_hsc   = (function_code == `ITU_FC_START_T2) &
                   hsc0_enabled;                              // see [RULE16]
  wire cmd_err   = cmd_wr & (err_bad | err_area | err_bcd | err_ival |
                   err_subr | err_pulse | err_hsc);
  wire cmd_ok    = cmd_wr & ~cmd_err;

  // Per-timer counters
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_tmr
      reg        run;
      reg        sched;
      reg        expire;
      reg [14:0] pre;
      reg [15:0] init;
      reg [15:0] remain;
      reg [15:0] done;
      reg [15:0] ival;
      reg [15:0] elap;
      reg [15:0] sub;
      wire       sel   = (tsel == i);
      wire       start = cmd_ok & is_start & sel;
      wire       stop  = cmd_ok & (kind == `ITU_K_STOP) & sel; // see [RULE4]
      wire       tick  = (pre == TICK_LAST);
      wire [15:0] elap_n = bcd_step(elap, 1'b1);

      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          run    <= 1'b0;
          sched  <= 1'b0;
          expire <= 1'b0;
          pre    <= 15'h0000;
          init   <= 16'h0000;
          remain <= 16'h0000;
          done   <= 16'h0000;
          ival   <= `ITU_IVAL_IMM;
          elap   <= 16'h0000;
          sub    <= 16'h0000;
        end else begin
          expire <= 1'b0;
          if (start) begin
            sched  <= (kind == `ITU_K_SCHED);                 // see [RULE2]
            init   <= count_operand;                          // see [RULE6]
            remain <= count_operand;
            done   <= 16'h0000;
            elap   <= 16'h0000;
            pre    <= 15'h0000;
            sub    <= subroutine_operand;                     // see [RULE9]
            ival   <= word_mode ? interval_operand
                                : `ITU_IVAL_IMM;              // see [RULE7]
            // A zero count expires at once and never reloads
            if (count_operand == 16'h0000) begin
              run    <= 1'b0;
              expire <= 1'b1;                                 // see [RULE8]
            end else begin
              run    <= 1'b1;                                 // see [RULE1]
            end
          end else if (stop) begin
            run <= 1'b0;                                      // see [RULE19]
          end else if (run) begin
            pre <= tick ? 15'h0000 : pre + 15'h0001;
            if (tick) begin
              if (elap_n == ival) begin
                elap <= 16'h0000;
                if (remain == 16'h0001) begin
                  expire <= 1'b1;                             // see [RULE8]
                  if (sched) begin
                    remain <= init;                           // see [RULE18]
                    done   <= 16'h0000;
                  end else begin
                    run    <= 1'b0;                           // see [RULE18]
                    remain <= 16'h0000;
                    done   <= bcd_step(done, 1'b1);
                  end
                end else begin
                  remain <= bcd_step(remain, 1'b0);
                  done   <= bcd_step(done, 1'b1);             // see [RULE11]
                end
              end else begin
                elap <= elap_n;                               // see [RULE12]
              end
            end
          end
        end
      end

      assign run_flat[i]          = run;
      assign sched_flat[i]        = sched;
      assign exp_flat[i]          = expire;
      assign sub_flat[16*i +: 16]  = sub;
      assign done_flat[16*i +: 16] = done;
      assign ival_flat[16*i +: 16] = ival;
      assign elap_flat[16*i +: 16] = elap;
    end
  endgenerate

  // Pending expiries; a new expiry beats the grant that clears it
  wire [2:0] kill;
  wire [2:0] grant;
  wire       kill_any = cmd_ok & (is_start | (kind == `ITU_K_STOP));
  assign kill     = kill_any ? (3'b001 << tsel) : 3'b000;
  assign grant[0] = pend[0];
  assign grant[1] = pend[1] & ~pend[0];
  assign grant[2] = pend[2] & ~pend[1] & ~pend[0];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend           <= 3'b000;
      irq_valid      <= 1'b0;
      irq_timer      <= 2'd0;
      irq_subroutine <= 16'h0000;
    end else begin
      pend      <= exp_flat | (pend & ~grant & ~kill);        // see [RULE19]
      irq_valid <= |(grant & ~kill);
      if (grant[0]) begin
        irq_timer      <= 2'd0;
        irq_subroutine <= sub_flat[15:0];                     // see [RULE9]
      end else if (grant[1]) begin
        irq_timer      <= 2'd1;
        irq_subroutine <= sub_flat[31:16];
      end else if (grant[2]) begin
        irq_timer      <= 2'd2;
        irq_subroutine <= sub_flat[47:32];
      end
    end
  end

  // Operand and result registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_word           <= `ITU_RST_WORD;
      count_operand      <= 16'h0000;
      interval_operand   <= 16'h0000;
      subroutine_operand <= 16'h0000;
      rd_count           <= 16'h0000;
      rd_ival            <= 16'h0000;
      rd_elap            <= 16'h0000;
      error_flag         <= 1'b0;
    end else begin
      if (wr_acc) begin
        if (paddr == `ITU_OFF_CMD) begin
          cmd_word <= pwdata;
        end else if (paddr == `ITU_OFF_COUNT) begin
          count_operand <= pwdata[15:0];
        end else if (paddr == `ITU_OFF_INTERVAL) begin
          interval_operand <= pwdata[15:0];
        end else if (paddr == `ITU_OFF_SUBR) begin
          subroutine_operand <= pwdata[15:0];
        end
      end
      if (cmd_ok && kind == `ITU_K_READ) begin
        rd_count <= done_flat[{tsel, 4'h0} +: 16];            // see [RULE3]
        rd_ival  <= ival_flat[{tsel, 4'h0} +: 16];            // see [RULE11]
        rd_elap  <= elap_flat[{tsel, 4'h0} +: 16];            // see [RULE13]
      end
      // Set wins over a write-one clear in the same cycle
      if (cmd_err) begin
        error_flag <= 1'b1;                                   // see [RULE17]
      end else if (st_wr && pwdata[`ITU_ST_ERR_BIT]) begin
        error_flag <= 1'b0;
      end
    end
  end

  // APB slave: no wait states, ready raised after the setup cycle
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `ITU_OFF_STATUS);
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (paddr == `ITU_OFF_CMD) begin
      rd_mux = cmd_word;
    end else if (paddr == `ITU_OFF_COUNT) begin
      rd_mux[15:0] = count_operand;
    end else if (paddr == `ITU_OFF_INTERVAL) begin
      rd_mux[15:0] = interval_operand;
    end else if (paddr == `ITU_OFF_SUBR) begin
      rd_mux[15:0] = subroutine_operand;
    end else if (paddr == `ITU_OFF_RD_COUNT) begin
      rd_mux[15:0] = rd_count;
    end else if (paddr == `ITU_OFF_RD_IVAL) begin
      rd_mux[15:0] = rd_ival;
    end else if (paddr == `ITU_OFF_RD_ELAP) begin
      rd_mux[15:0] = rd_elap;
    end else if (paddr == `ITU_OFF_STATUS) begin
      rd_mux[`ITU_ST_ERR_BIT] = error_flag;
      rd_mux[`ITU_ST_RUN_LSB +: 3]   = run_flat;
      rd_mux[`ITU_ST_SCHED_LSB +: 3] = sched_flat;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      if (psel && !penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

endmodule

// ---- itu_top_sva.sv ----
// Checker for the interval timer unit ports
`timescale 1ns/1ps
`include "itu_defs.vh"
module itu_top_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire        clk,                 // Clock
  input wire        rstn,                // Reset
  input wire        psel,                // Select
  input wire        penable,             // Enable
  input wire        pwrite,              // Direction
  input wire [7:0]  paddr,               // Address
  input wire [31:0] pwdata,              // Write data
  input wire [31:0] prdata,              // Read data
  input wire        pready,              // Ready
  input wire        pslverr,             // Error
  input wire        pulse_output_active, // Pulse busy
  input wire        hsc0_enabled,        // Counter 0 on
  input wire        irq_valid,           // Expiry
  input wire [1:0]  irq_timer,           // Timer
  input wire [15:0] irq_subroutine,      // Subroutine
  input wire        error_flag           // Error
);
  reg  [15:0] ival;
  reg  [15:0] subr;
  wire        acc   = psel && penable && pready && pwrite;
  wire        cmd   = acc && (paddr == `ITU_OFF_CMD);
  wire [11:0] fc    = pwdata[11:0];
  wire        start = cmd && (fc <= `ITU_FC_SCH_LAST);
  // Operand shadows, so start checks see what the command will use
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ival <= 16'h0000;
      subr <= 16'h0000;
    end else if (acc && paddr == `ITU_OFF_INTERVAL) begin
      ival <= pwdata[15:0];
    end else if (acc && paddr == `ITU_OFF_SUBR) begin
      subr <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_irq_timer_range: assert property (
    irq_valid |-> irq_timer <= 2'd2) else $error("bad irq timer");
  a_irq_subr_bcd: assert property (
    irq_valid |-> irq_subroutine <= `ITU_SUBR_MAX &&
    irq_subroutine[3:0] <= 4'h9 && irq_subroutine[7:4] <= 4'h9)
    else $error("bad irq subroutine");
  a_bad_code_err: assert property (
    cmd && (fc == 12'h009 || fc > `ITU_FC_STP_LAST) |-> ##[1:2] error_flag)
    else $error("invalid code not flagged");
  a_ival_range_err: assert property (
    start && pwdata[`ITU_CMD_WORD_BIT] &&
    (ival < `ITU_IVAL_MIN || ival > `ITU_IVAL_MAX) |-> ##[1:2] error_flag)
    else $error("interval range not flagged");
  a_subr_max_err: assert property (
    start && subr > `ITU_SUBR_MAX |-> ##[1:2] error_flag)
    else $error("subroutine range not flagged");
  a_pulse_t0_err: assert property (
    cmd && fc == `ITU_FC_ONE_FIRST && pulse_output_active |-> ##[1:2]
    error_flag) else $error("timer 0 conflict not flagged");
  a_hsc_t2_err: assert property (
    cmd && fc == `ITU_FC_START_T2 && hsc0_enabled |-> ##[1:2] error_flag)
    else $error("timer 2 conflict not flagged");
  a_area_fault_err: assert property (
    cmd && pwdata[`ITU_CMD_AREA_BIT] && fc < `ITU_FC_STP_FIRST |->
    ##[1:2] error_flag) else $error("area fault not flagged");
  a_error_sticky: assert property (
    error_flag && !(acc && paddr == `ITU_OFF_STATUS && pwdata[0]) |=>
    error_flag) else $error("error flag dropped");
endmodule
bind itu_top itu_top_sva #(.TICK_CYCLES(TICK_CYCLES)) itu_top_sva_i (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pulse_output_active(pulse_output_active),
  .hsc0_enabled(hsc0_enabled), .irq_valid(irq_valid), .irq_timer(irq_timer),
  .irq_subroutine(irq_subroutine), .error_flag(error_flag));

// ---- itu_apb_master.sv ----
// APB master model standing in for the processor core
`timescale 1ns/1ps
module itu_apb_master (
  input  wire        clk,     // Clock
  output reg         psel,    // Select
  output reg         penable, // Enable
  output reg         pwrite,  // Direction
  output reg  [7:0]  paddr,   // Address
  output reg  [31:0] pwdata,  // Write data
  input  wire [31:0] prdata,  // Read data
  input  wire        pready,  // Ready
  input  wire        pslverr  // Error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Reads always land in registers, never constants
  task xfer(input w, input [7:0] a, input [31:0] d,
            output [31:0] q, output e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here; the bench watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- test_itu_top.sv ----
// Self-checking testbench for the interval timer unit
`timescale 1ns/1ps
`include "itu_defs.vh"
module test_itu_top;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         pulse_output_active = 1'b0;
  reg         hsc0_enabled = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr, irq_valid, error_flag;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  wire [1:0]  irq_timer;
  wire [15:0] irq_subroutine;
  integer     fail_count = 0;
  integer     checks_done = 0;
  integer     irq_n = 0;
  integer     c, k;
  reg  [31:0] q, r;
  always #2 clk = ~clk;
  always @(posedge clk) if (irq_valid === 1'b1) irq_n <= irq_n + 1;
  itu_top #(.TICK_CYCLES(4)) itu_top_i (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_output_active(pulse_output_active), .hsc0_enabled(hsc0_enabled),
    .irq_valid(irq_valid), .irq_timer(irq_timer),
    .irq_subroutine(irq_subroutine), .error_flag(error_flag));
  itu_apb_master itu_apb_master_i (.clk(clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task check(input string what, input logic [31:0] seen, exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg e;
    itu_apb_master_i.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input [7:0] a, output [31:0] d);
    reg e;
    itu_apb_master_i.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  task ops(input [15:0] cnt, iv, sb);
    wr(`ITU_OFF_COUNT, {16'h0000, cnt});
    wr(`ITU_OFF_INTERVAL, {16'h0000, iv});
    wr(`ITU_OFF_SUBR, {16'h0000, sb});
  endtask
  task wait_irq(input integer lim);
    c = 0;
    while (c < lim && irq_valid !== 1'b1) begin
      @(posedge clk);
      #1;
      c = c + 1;
    end
  endtask
  task t_reset;
    reg e;
    check("rst_err", error_flag, 1'b0);
    rd(`ITU_OFF_STATUS, q);
    check("rst_status", q, `ITU_RST_WORD);
    itu_apb_master_i.xfer(1'b0, 8'h20, 32'h0000_0000, q, e);
    check("unmapped_err", e, 1'b1);
    $display("test reset done");
  endtask
  task t_oneshot;
    ops(16'h0003, 16'h0005, 16'h0042);
    wr(`ITU_OFF_CMD, 32'h0001_0001);
    wait_irq(200);
    check("os_delay", c, 62);
    check("os_timer", irq_timer, 2'd1);
    check("os_subr", irq_subroutine, 16'h0042);
    k = irq_n + 1;
    repeat (150) @(posedge clk);
    check("os_halt", irq_n, k);
    wr(`ITU_OFF_CMD, 32'h0000_0007);
    rd(`ITU_OFF_RD_COUNT, q);
    check("os_rd_count", q, 32'h0000_0003);
    rd(`ITU_OFF_RD_IVAL, q);
    check("os_rd_ival", q, 32'h0000_0005);
    rd(`ITU_OFF_STATUS, q);
    check("os_status", q, 32'h0000_0000);
    $display("test oneshot done");
  endtask
  task t_sched;
    hsc0_enabled <= 1'b1;
    ops(16'h0002, 16'h0320, 16'h0255);
    wr(`ITU_OFF_CMD, 32'h0000_0005);
    wait_irq(300);
    check("sc_delay1", c, 82);
    check("sc_timer", irq_timer, 2'd2);
    check("sc_subr", irq_subroutine, 16'h0255);
    rd(`ITU_OFF_STATUS, q);
    check("sc_status", q, 32'h0000_0048);
    wait_irq(300);
    // Period of 80 cycles less the 3 cycles of the status read
    check("sc_delay2", c, 77);
    wr(`ITU_OFF_CMD, 32'h0000_0012);
    k = irq_n;
    repeat (200) @(posedge clk);
    check("sc_stopped", irq_n, k);
    check("sc_no_err", error_flag, 1'b0);
    hsc0_enabled <= 1'b0;
    $display("test sched done");
  endtask
  task err_case(input [31:0] w, input [15:0] cnt, iv, sb, input po, hs);
    pulse_output_active <= po;
    hsc0_enabled <= hs;
    ops(cnt, iv, sb);
    wr(`ITU_OFF_CMD, w);
    rd(`ITU_OFF_STATUS, q);
    check("err_set", q[0], 1'b1);
    check("err_refused", q[3:1], 3'd0);
    wr(`ITU_OFF_STATUS, 32'h0000_0001);
    rd(`ITU_OFF_STATUS, q);
    check("err_clear", q[0], 1'b0);
    pulse_output_active <= 1'b0;
    hsc0_enabled <= 1'b0;
  endtask
  task t_errors;
    k = irq_n;
    err_case(32'h0000_0009, 16'h0003, 16'h0005, 16'h0001, 0, 0);
    err_case(32'h0000_0013, 16'h0003, 16'h0005, 16'h0001, 0, 0);
    err_case(32'h0001_0001, 16'h0003, 16'h0321, 16'h0001, 0, 0);
    err_case(32'h0001_0001, 16'h0003, 16'h0004, 16'h0001, 0, 0);
    err_case(32'h0000_0004, 16'h0003, 16'h0005, 16'h0256, 0, 0);
    err_case(32'h0000_0001, 16'h000A, 16'h0005, 16'h0001, 0, 0);
    err_case(32'h0002_0003, 16'h0003, 16'h0005, 16'h0001, 0, 0);
    err_case(32'h0000_0000, 16'h0003, 16'h0005, 16'h0001, 1, 0);
    err_case(32'h0000_0002, 16'h0003, 16'h0005, 16'h0001, 0, 1);
    repeat (100) @(posedge clk);
    check("err_no_irq", irq_n, k);
    $display("test errors done");
  endtask
  task t_elapsed;
    ops(16'h0009, 16'h0005, 16'h0007);
    wr(`ITU_OFF_CMD, 32'h0001_0000);
    repeat (47) @(posedge clk);
    wr(`ITU_OFF_CMD, 32'h0000_0006);
    rd(`ITU_OFF_RD_COUNT, q);
    rd(`ITU_OFF_RD_ELAP, r);
    check("el_part", r <= 32'h0000_0005, 1'b1);
    // Bus edges can shift the sample by one tick either way
    k = q * 5 + r;
    check("el_total", k >= 11 && k <= 13, 1'b1);
    rd(`ITU_OFF_RD_IVAL, r);
    check("el_ival", r, 32'h0000_0005);
    wr(`ITU_OFF_CMD, 32'h0000_0010);
    k = irq_n;
    repeat (200) @(posedge clk);
    check("el_stopped", irq_n, k);
    wr(`ITU_OFF_CMD, 32'h0000_0006);
    rd(`ITU_OFF_RD_COUNT, r);
    check("el_frozen", r >= q && r <= q + 1, 1'b1);
    $display("test elapsed done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #80000;
    fail_count = fail_count + 1;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_oneshot;
    t_sched;
    t_errors;
    t_elapsed;
    finish_test;
  end
endmodule
